// >>> rtl/lpm_consts.svh
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing counts and bit positions
// ----------------------------------------------------------------------
`define LPM_CLK_PERIOD_NS 10
`define LPM_OSC_SETTLE_US 1000
`define LPM_OSC_SETTLE_CYC ((`LPM_OSC_SETTLE_US * 1000) / `LPM_CLK_PERIOD_NS)
`define LPM_PLL_LOCK_US 100
`define LPM_PLL_LOCK_CYC ((`LPM_PLL_LOCK_US * 1000) / `LPM_CLK_PERIOD_NS)
`define LPM_HOLD_BIT 0
`define LPM_SUSP_BIT 1
`define LPM_STBY_BIT 2
`define LPM_WAKE_D_BIT 0
`define LPM_WAKE_CTL_BIT 1
`define LPM_WAKE_VBUS_BIT 2

`endif

// >>> rtl/lpm_pkg.sv
package lpm_pkg;

  typedef enum logic [3:0] {
    ST_RUN,
    ST_QUIESCE,
    ST_SUSPEND,
    ST_STANDBY,
    ST_OSC_START,
    ST_PLL_START,
    ST_RESUME
  } lpm_state_e;

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_SUSPEND,
    MODE_STANDBY
  } lpm_mode_e;

endpackage : lpm_pkg

// >>> rtl/lpm_sync.sv
`timescale 1ns/10ps
`default_nettype none

module lpm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } lpm_sync_s;

  lpm_sync_s s_reg;
  lpm_sync_s s_next;

  // ----------------------------------------------------------------------
  // Two-flop synchroniser per bit
  // ----------------------------------------------------------------------
  // Only the second stage is read, so a metastable first stage has a
  // whole cycle to settle before any logic sees it.
  always_comb
  begin
    s_next.stage1 = async_in;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stage2;

endmodule : lpm_sync

`default_nettype wire

// >>> rtl/lpm_ctrl.sv
// Behaviour
// - Firmware request enters suspend with PHY off.
// - Mailbox request also enters suspend.
// - Suspend disables SuperSpeed PHY, USB suspended.
// - Suspend gates clocks and disables PLLs.
// - Pins hold pre-entry state during suspend.
// - USB logic keeps its state in suspend.
// - Registers, buffers, RAM retained in suspend.
// - Transfers must finish before suspend request; a request made while XFER_BUSY is high waits in quiesce until it falls.
// - Non-reset suspend wake keeps program counter.
// - Any data line change wakes suspend.
// - Wake line or hard reset wakes suspend.
// - Standby keeps registers and program RAM.
// - Buffer data may be lost in standby.
// - Standby wake resets program counter.
// - GPIO keep configuration through standby.
// - Standby stops oscillator and PLL.
// - Firmware or host register write enters standby.
// - VBUS, wake line, or reset exit standby.
`timescale 1ns/10ps
`default_nettype none
`include "lpm_consts.svh"

module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int OSC_SETTLE_CYC = `LPM_OSC_SETTLE_CYC,
  parameter int PLL_LOCK_CYC = `LPM_PLL_LOCK_CYC,
  parameter int CNT_W = 20
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic HARD_RESET_N,
  input wire logic FW_SUSPEND_REQ,
  input wire logic MBOX_SUSPEND_REQ,
  input wire logic FW_STANDBY_REQ,
  input wire logic HOST_STANDBY_REQ,
  input wire logic XFER_BUSY,
  input wire logic USB_DP,
  input wire logic USB_DM,
  input wire logic PARALLEL_WAKE_LINE,
  input wire logic VBUS_DET,
  input wire logic OSC_STABLE,
  input wire logic PLL_LOCKED,
  output logic SS_PHY_EN,
  output logic USB_SUSPEND,
  output logic CLK_GATE_EN,
  output logic PLL_EN,
  output logic OSC_EN,
  output logic IO_HOLD,
  output logic USB_STATE_HOLD,
  output logic RAM_RETAIN,
  output logic BUF_VALID,
  output logic CPU_RUN,
  output logic CPU_PC_RESET,
  output logic CORE_RESET,
  output logic [1:0] LP_MODE
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    lpm_state_e state;
    lpm_mode_e mode;
    logic pc_reset;
    logic buf_valid;
    logic dp_last;
    logic dm_last;
    logic [CNT_W-1:0] cnt;
    logic cpu_pc_reset;
    logic core_reset;
  } lpm_ctrl_s;

  lpm_ctrl_s s_reg;
  lpm_ctrl_s s_next;

  localparam lpm_ctrl_s RESET_VAL = '{
    state: ST_RUN,
    mode: MODE_NONE,
    pc_reset: 1'b0,
    buf_valid: 1'b1,
    dp_last: 1'b0,
    dm_last: 1'b0,
    cnt: '0,
    cpu_pc_reset: 1'b0,
    core_reset: 1'b0
  };

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] pin_sync;
  logic dp_s;
  logic dm_s;
  logic ctl_s;
  logic vbus_s;
  logic hard_rst_s;
  logic [1:0] stab_sync;

  lpm_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .async_in({!HARD_RESET_N, VBUS_DET, PARALLEL_WAKE_LINE, USB_DM, USB_DP}),
    .sync_out(pin_sync)
  );

  // Oscillator and PLL status come from analog cells, so they are
  // treated as asynchronous as well.
  lpm_sync #(
    .WIDTH(2)
  ) u_stab_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .async_in({PLL_LOCKED, OSC_STABLE}),
    .sync_out(stab_sync)
  );

  assign dp_s = pin_sync[0];
  assign dm_s = pin_sync[1];
  assign ctl_s = pin_sync[2];
  assign vbus_s = pin_sync[3];
  assign hard_rst_s = pin_sync[4];

  // ----------------------------------------------------------------------
  // Request and wake decode
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_LOCK_CYC - 1);

  logic susp_req;
  logic stby_req;
  logic dp_moved;
  logic dm_moved;
  logic line_change;
  logic susp_wake;
  logic stby_wake;
  logic osc_done;
  logic pll_done;
  logic osc_ready;
  logic pll_ready;

  // A line counts as moved only against the level latched in run and quiesce,
  // so a line parked high or low through suspend never wakes the part.
  always_comb
  begin
    susp_req = FW_SUSPEND_REQ || MBOX_SUSPEND_REQ;
    stby_req = FW_STANDBY_REQ || HOST_STANDBY_REQ;
    dp_moved = (dp_s != s_reg.dp_last);
    dm_moved = (dm_s != s_reg.dm_last);
    line_change = dp_moved || dm_moved;
    susp_wake = line_change || ctl_s;
    stby_wake = vbus_s || ctl_s;
    osc_done = (s_reg.cnt == OSC_LAST);
    pll_done = (s_reg.cnt == PLL_LAST);
    osc_ready = stab_sync[0];
    pll_ready = stab_sync[1];
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.cpu_pc_reset = 1'b0;
    s_next.core_reset = 1'b0;
    unique case (s_reg.state)
      ST_RUN:
      begin
        s_next.dp_last = dp_s;
        s_next.dm_last = dm_s;
        if (stby_req || susp_req)
        begin
          // Standby wins when both are asked for in one cycle.
          if (stby_req)
          begin
            s_next.mode = MODE_STANDBY;
          end
          else
          begin
            s_next.mode = MODE_SUSPEND;
          end
          s_next.state = ST_QUIESCE;
        end
      end
      ST_QUIESCE:
      begin
        // A transfer still in flight would be cut mid-way, so entry waits
        // for the data path to drain instead of losing its progress.
        s_next.dp_last = dp_s;
        s_next.dm_last = dm_s;
        if (!XFER_BUSY)
        begin
          if (s_reg.mode == MODE_STANDBY)
          begin
            s_next.state = ST_STANDBY;
            s_next.buf_valid = 1'b0;
          end
          else
          begin
            s_next.state = ST_SUSPEND;
          end
        end
      end
      ST_SUSPEND:
      begin
        if (susp_wake)
        begin
          s_next.pc_reset = 1'b0;
          s_next.state = ST_OSC_START;
          s_next.cnt = '0;
        end
      end
      ST_STANDBY:
      begin
        if (stby_wake)
        begin
          s_next.pc_reset = 1'b1;
          s_next.state = ST_OSC_START;
          s_next.cnt = '0;
        end
      end
      ST_OSC_START:
      begin
        // Both the settle time and the stable flag are needed; the flag
        // alone can glitch high while the crystal is still building up.
        if (!osc_done)
        begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
        else if (osc_ready)
        begin
          s_next.state = ST_PLL_START;
          s_next.cnt = '0;
        end
      end
      ST_PLL_START:
      begin
        if (!pll_done)
        begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
        else if (pll_ready)
        begin
          s_next.state = ST_RESUME;
        end
      end
      ST_RESUME:
      begin
        s_next.cpu_pc_reset = s_reg.pc_reset;
        s_next.buf_valid = 1'b1;
        s_next.mode = MODE_NONE;
        s_next.state = ST_RUN;
      end
      default:
      begin
        s_next.state = ST_RUN;
      end
    endcase
    // Hard reset overrides every state and always restarts the program.
    if (hard_rst_s)
    begin
      s_next.state = ST_RUN;
      s_next.mode = MODE_NONE;
      s_next.pc_reset = 1'b1;
      s_next.cpu_pc_reset = 1'b1;
      s_next.core_reset = 1'b1;
      s_next.buf_valid = 1'b1;
      s_next.cnt = '0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      s_reg <= RESET_VAL;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic in_run;
  logic in_suspend;
  logic in_standby;
  logic in_osc_start;
  logic in_pll_start;
  logic low_power;
  logic clocks_down;
  logic pll_off;

  // The PLL stays off until the crystal has settled, since a PLL locking
  // onto a half-built reference may lock at a wrong frequency.
  always_comb
  begin
    in_run = (s_reg.state == ST_RUN);
    in_suspend = (s_reg.state == ST_SUSPEND);
    in_standby = (s_reg.state == ST_STANDBY);
    in_osc_start = (s_reg.state == ST_OSC_START);
    in_pll_start = (s_reg.state == ST_PLL_START);
    low_power = in_suspend || in_standby;
    clocks_down = low_power || in_osc_start || in_pll_start;
    pll_off = low_power || in_osc_start;
  end

  assign SS_PHY_EN = !clocks_down;
  assign USB_SUSPEND = clocks_down;
  assign CLK_GATE_EN = !clocks_down;
  assign PLL_EN = !pll_off;
  assign OSC_EN = !low_power;
  assign IO_HOLD = clocks_down;
  assign USB_STATE_HOLD = clocks_down;
  assign RAM_RETAIN = clocks_down;

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  assign BUF_VALID = s_reg.buf_valid;
  assign CPU_RUN = in_run;
  assign CPU_PC_RESET = s_reg.cpu_pc_reset;
  assign CORE_RESET = s_reg.core_reset;
  assign LP_MODE = s_reg.mode;

endmodule : lpm_ctrl

`default_nettype wire

// >>> tb/lpm_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------
// Port checker
// --------------------
module lpm_ctrl_monitor #(
  parameter int OSC_SETTLE_CYC = 4
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic HARD_RESET_N,
  input wire logic FW_SUSPEND_REQ,
  input wire logic MBOX_SUSPEND_REQ,
  input wire logic FW_STANDBY_REQ,
  input wire logic HOST_STANDBY_REQ,
  input wire logic XFER_BUSY,
  input wire logic USB_DP,
  input wire logic USB_DM,
  input wire logic PARALLEL_WAKE_LINE,
  input wire logic VBUS_DET,
  input wire logic SS_PHY_EN,
  input wire logic CLK_GATE_EN,
  input wire logic PLL_EN,
  input wire logic OSC_EN,
  input wire logic IO_HOLD,
  input wire logic CPU_RUN,
  input wire logic [1:0] LP_MODE
);
  int osc_cnt;
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // A counter keeps the settle check free of a long repetition.
  always_ff @(posedge CLK_SYS)
    osc_cnt <= (OSC_EN && !PLL_EN) ? osc_cnt + 1 : 0;
  sequence s_susp; !OSC_EN && LP_MODE == 2'h1; endsequence
  sequence s_stby; !OSC_EN && LP_MODE == 2'h2; endsequence
  property p_sleep;
    !OSC_EN |-> !CLK_GATE_EN && !PLL_EN && !SS_PHY_EN && IO_HOLD;
  endproperty
  a_sleep:
  assert property (p_sleep) else $error("sleep outputs");
  property p_susp;
    CPU_RUN && (FW_SUSPEND_REQ || MBOX_SUSPEND_REQ) && !FW_STANDBY_REQ
      && !HOST_STANDBY_REQ |=> LP_MODE == 2'h1;
  endproperty
  a_susp:
  assert property (p_susp) else $error("suspend entry");
  property p_stby;
    CPU_RUN && (FW_STANDBY_REQ || HOST_STANDBY_REQ) |=> LP_MODE == 2'h2;
  endproperty
  a_stby: assert property (p_stby) else $error("standby entry");
  property p_busy;
    !CPU_RUN && CLK_GATE_EN && LP_MODE != 2'h0 && XFER_BUSY |=> CLK_GATE_EN;
  endproperty
  a_busy: assert property (p_busy) else $error("entry while busy");
  property p_wake_s;
    s_susp ##0 ($changed(USB_DP) || $changed(USB_DM) || PARALLEL_WAKE_LINE)
      |-> ##[1:4] OSC_EN;
  endproperty
  a_wake_s:
  assert property (p_wake_s) else $error("suspend wake");
  property p_wake_t;
    s_stby ##0 (VBUS_DET || PARALLEL_WAKE_LINE) |-> ##[1:4] OSC_EN;
  endproperty
  a_wake_t: assert property (p_wake_t) else $error("standby wake");
  property p_hrst;
    $fell(HARD_RESET_N) |-> ##[1:4] CPU_RUN;
  endproperty
  a_hrst: assert property (p_hrst) else $error("hard reset");
  property p_settle;
    $rose(PLL_EN) && !CLK_GATE_EN |-> osc_cnt >= OSC_SETTLE_CYC;
  endproperty
  a_settle: assert property (p_settle) else $error("settle wait");
endmodule : lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor #(.OSC_SETTLE_CYC(OSC_SETTLE_CYC)) u_mon (
  .CLK_SYS, .NRST, .HARD_RESET_N, .FW_SUSPEND_REQ, .MBOX_SUSPEND_REQ,
  .FW_STANDBY_REQ, .HOST_STANDBY_REQ, .XFER_BUSY, .USB_DP, .USB_DM,
  .PARALLEL_WAKE_LINE, .VBUS_DET, .SS_PHY_EN, .CLK_GATE_EN, .PLL_EN,
  .OSC_EN, .IO_HOLD, .CPU_RUN, .LP_MODE);
`default_nettype wire

// >>> tb/lpm_clk_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------
// Oscillator and PLL
// --------------------
module lpm_clk_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic osc_en,
  input wire logic pll_en,
  output logic osc_stable,
  output logic pll_locked
);
  int osc_cnt = 0;
  int pll_cnt = 0;
  // Status falls with its enable, so no stale lock survives a sleep.
  always @(posedge clk)
  begin
    osc_cnt <= osc_en ? osc_cnt + 1 : 0;
    pll_cnt <= pll_en ? pll_cnt + 1 : 0;
  end
  assign osc_stable = osc_en && osc_cnt > (slow ? 12 : 1);
  assign pll_locked = pll_en && pll_cnt > (slow ? 9 : 1);
endmodule : lpm_clk_model
`default_nettype wire

// >>> tb/tb_low_power_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------
// Sleep and wake bench
// --------------------
module tb_low_power_mode_control;
  logic clk = 0, nrst = 0, hrn = 1, fws = 0, mbs = 0, fwt = 0, hst = 0;
  logic busy = 0, dp = 0, dm = 1, wk = 0, vb = 0, slow = 0;
  logic osk, plk, phy, usp, gate, pll, osc, hld, uhl, ram, bufv, run, pcr, cor;
  logic [1:0] mode;
  logic [15:0] rnd = 16'h033d;
  int miscompares = 0, total_checks = 0, exp_q[$];
  always #5 clk = ~clk;
  lpm_ctrl #(.OSC_SETTLE_CYC(4), .PLL_LOCK_CYC(3)) dut (.CLK_SYS(clk),
    .NRST(nrst), .HARD_RESET_N(hrn), .FW_SUSPEND_REQ(fws),
    .MBOX_SUSPEND_REQ(mbs), .FW_STANDBY_REQ(fwt), .HOST_STANDBY_REQ(hst),
    .XFER_BUSY(busy), .USB_DP(dp), .USB_DM(dm), .PARALLEL_WAKE_LINE(wk),
    .VBUS_DET(vb), .OSC_STABLE(osk), .PLL_LOCKED(plk), .SS_PHY_EN(phy),
    .USB_SUSPEND(usp), .CLK_GATE_EN(gate), .PLL_EN(pll), .OSC_EN(osc),
    .IO_HOLD(hld), .USB_STATE_HOLD(uhl), .RAM_RETAIN(ram),
    .BUF_VALID(bufv), .CPU_RUN(run), .CPU_PC_RESET(pcr),
    .CORE_RESET(cor), .LP_MODE(mode));
  lpm_clk_model prt (.clk(clk), .slow(slow), .osc_en(osc), .pll_en(pll),
    .osc_stable(osk), .pll_locked(plk));
  function logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task close_out;
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
    if (n == "wait" && g !== e)
      close_out;
  endtask : chk
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task run_one(input int kind, input int src);
    int m, n, k;
    logic pc, cr;
    m = kind > 1 ? 2 : 1;
    exp_q.push_back(m);
    rnd = lfsr(rnd);
    slow = rnd[0];
    busy = 1;
    fws = kind == 0 || kind == 4;
    mbs = kind == 1;
    fwt = kind == 2 || kind == 4;
    hst = kind == 3;
    step;
    {fws, mbs, fwt, hst} = 4'h0;
    repeat (2 + rnd[3:1]) step;
    chk("busy", 4'h1, {3'h0, gate});
    busy = 0;
    for (n = 0; n < 20 && gate !== 0; n++) step;
    chk("wait", 4'h1, {3'h0, n < 20});
    chk("mode", exp_q.pop_front(), {2'h0, mode});
    chk("sleep", 4'h1, {osc,pll,phy,hld});
    chk("usbsusp", 4'h1, {3'h0, usp});
    chk("keep", {3'h3,m<2}, {1'b0,uhl,ram,bufv});
    // Each refused source is the one the other mode would accept.
    vb = m == 1;
    dp = (m == 2) ^ dp;
    repeat (8) step;
    chk("refuse", 4'h0, {3'h0, osc});
    vb = m == 2 && src == 0;
    dp = (m == 1 && src == 0) ^ dp;
    wk = src == 1;
    hrn = src != 2;
    dm = (src == 3) ^ dm;
    {pc, cr, k} = 0;
    for (n = 0; n < 80 && k < 3; n++)
    begin
      step;
      pc |= pcr;
      cr |= cor;
      if (n == 3) hrn = 1;
      if (run === 1 && n > 3) k++;
    end
    {wk, vb} = 2'h0;
    chk("wait", 4'h1, {3'h0, n < 80});
    chk("pc", {3'h0, m == 2 || src == 2}, {3'h0, pc});
    chk("core", {3'h0, src == 2}, {3'h0, cr});
    chk("up", 4'hf, {osc, pll, gate, bufv});
    chk("awake", 4'h2, {2'h0, phy, usp});
    chk("free", 4'h0, {1'b0, hld, uhl, ram});
  endtask : run_one
  initial
  begin
    repeat (10) step;
    nrst = 1;
    chk("reset", 4'h9, {run, mode, bufv});
    for (int i = 0; i < 7; i++)
      run_one(i < 4 ? i % 2 : i - 2, i < 4 ? i : i - 4);
    close_out;
  end
endmodule : tb_low_power_mode_control
`default_nettype wire
